// *** src/ppm_pkg.sv ***
package ppm_pkg;
	// ****************************************
	// Register map (byte addresses)
	// ****************************************
	localparam logic [7:0] PPM_OFS_CAP = 8'hC0;
	localparam logic [7:0] PPM_OFS_CSR = 8'hC4;
	localparam logic [7:0] PPM_OFS_LOCK = 8'hC8;
	localparam logic [7:0] PPM_OFS_EVT = 8'hCC;

	// ****************************************
	// Field layout and reset values
	// ****************************************
	localparam logic [7:0] PPM_CAP_ID = 8'h01;
	localparam logic [7:0] PPM_NXT_UP = 8'h00;
	localparam logic [7:0] PPM_NXT_DN = 8'hD0;
	localparam logic [2:0] PPM_VERSION = 3'h3;
	localparam int PPM_SPECIAL_BIT = 21;
	localparam int PPM_PME_LSB = 27;
	localparam logic [4:0] PPM_PME_RST = 5'h19;
	localparam int PPM_NOSR_BIT = 3;
	localparam int PPM_EN_BIT = 8;
	localparam int PPM_ST_BIT = 15;
	localparam logic [1:0] PPM_PS_D0 = 2'h0;
	localparam logic [1:0] PPM_PS_D3 = 2'h3;
	localparam logic PPM_NOSR_RST = 1'b1;
	localparam logic [31:0] PPM_UNMAPPED = 32'h0000_0000;

	// ****************************************
	// Types
	// ****************************************
	typedef struct packed {
		logic [7:0] next_ptr;
		logic special;
		logic [4:0] pme_adv;
		logic [1:0] power_state_field;
		logic keep_ctx;
	} ppm_regs_t;

	typedef enum logic {
		PPM_IDLE,
		PPM_DONE
	} ppm_bus_state_t;
endpackage : ppm_pkg

// *** src/ppm_sticky.sv ***
`timescale 1ns/1ps
module ppm_sticky
	import ppm_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// Controls
	input wire logic set_en_write,
	input wire logic en_wdata,
	input wire logic st_set,
	input wire logic st_clr,
	// State
	output logic en_reg,
	output logic st_reg
);
	logic en_next;
	logic st_next;

	// ****************************************
	// Sticky bits: only power-on reset touches them
	// ****************************************
	always_comb begin
		en_next = set_en_write ? en_wdata : en_reg;
		// (RQ15) set beats clear
		st_next = st_set | (st_reg & ~st_clr);
	end

	// (RQ13) hot reset not wired here
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			en_reg <= 1'b0;
			st_reg <= 1'b0;
		end else begin
			en_reg <= en_next;
			st_reg <= st_next;
		end
	end
endmodule : ppm_sticky

// *** src/ppm_regs.sv ***
`timescale 1ns/1ps
// Contract
// (RQ1) Capability id reads 0x1; next pointer 0x0 upstream, 0xD0 downstream.
// (RQ2) Version field bits 18:16 reads 0x3.
// (RQ3) Bit 19 wake-event clock flag reads zero, read-only.
// (RQ4) Bit 21 special-init flag resets zero, lockable-writable.
// (RQ5) Aux current bits 24:22 read zero.
// (RQ6) Bits 25 and 26 read zero: no intermediate states.
// (RQ7) PME support bits 31:27 reset to 11001.
// (RQ8) Writing PME support changes only advertised value, not behaviour.
// (RQ9) No PME forwarding while in cold powered-off state.
// (RQ10) Power state bits 1:0: 0 full-on, 3 hot low-power.
// (RQ11) Context-kept bit 3 resets to one.
// (RQ12) Sticky enable bit 8 resets zero, allows PME generation.
// (RQ13) Hot reset leaves enable bit unchanged.
// (RQ14) Init loader sets enable for wake on cold exit; there is no loader here, and enable is set only by a CSR write.
// (RQ15) Status bit 15 sets on own PME; write one clears.
// (RQ16) Status not set by merely propagated PME.
// (RQ17) Upstream port never sets status.
// (RQ18) Data select, scale and data byte read zero.
// (RQ19) Bits 22 and 23 of control register read zero.
// (RQ20) Lockable fields writable only when unlocked.
// (RQ21) Power state writes of 1 or 2 are ignored.
module ppm_regs
	import ppm_pkg::*;
#(
	parameter bit UPSTREAM = 1'b0
) (
	// Clock and resets
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic hot_reset,
	// Avalon-MM slave
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Events
	input wire logic pme_local,
	input wire logic pme_fwd_in,
	input wire logic cold_off,
	// Status and messaging
	output logic pme_msg,
	output logic [1:0] power_state,
	output logic pme_enable
);
	// ****************************************
	// State
	// ****************************************
	ppm_bus_state_t bus_reg, bus_next;
	ppm_regs_t regs_reg, regs_next;
	logic lock_reg, lock_next;
	logic [31:0] rd_reg, rd_next;
	logic wait_reg, wait_next;
	logic msg_reg, msg_next;
	logic unused_ps;
	logic en_bit, st_bit;
	logic wr_csr, wr_ok, st_set, st_clr, gen_ok;
	logic [31:0] cap_word, csr_word;

	// Writes land only at the edge that sees waitrequest low, as the bus requires
	assign wr_ok = avs_write && bus_reg == PPM_DONE;
	assign wr_csr = wr_ok && avs_address == PPM_OFS_CSR;

	// ****************************************
	// Read words
	// ****************************************
	always_comb begin
		cap_word = 32'h0000_0000;
		// (RQ1) identifier and next pointer
		cap_word[7:0] = PPM_CAP_ID;
		cap_word[15:8] = regs_reg.next_ptr;
		// (RQ2) fixed version
		cap_word[18:16] = PPM_VERSION;
		// (RQ3) (RQ5) (RQ6) zero fields
		cap_word[PPM_SPECIAL_BIT] = regs_reg.special;
		// (RQ7) advertised support
		cap_word[31:PPM_PME_LSB] = regs_reg.pme_adv;
		csr_word = 32'h0000_0000;
		csr_word[1:0] = regs_reg.power_state_field;
		csr_word[PPM_NOSR_BIT] = regs_reg.keep_ctx;
		csr_word[PPM_EN_BIT] = en_bit;
		// (RQ18) (RQ19) data and bus fields zero
		csr_word[PPM_ST_BIT] = st_bit;
	end

	// ****************************************
	// Sticky enable and status
	// ****************************************
	// (RQ17) upstream never generates
	assign gen_ok = !UPSTREAM;
	// (RQ16) forwarded messages do not set status
	assign st_set = pme_local && gen_ok;
	assign st_clr = wr_csr && avs_byteenable[1] && avs_writedata[PPM_ST_BIT];

	ppm_sticky u_sticky (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.set_en_write(wr_csr && avs_byteenable[1]),
		.en_wdata(avs_writedata[PPM_EN_BIT]),
		.st_set(st_set),
		.st_clr(st_clr),
		.en_reg(en_bit),
		.st_reg(st_bit)
	);

	// ****************************************
	// Register and bus next state
	// ****************************************
	always_comb begin
		regs_next = regs_reg;
		lock_next = lock_reg;
		bus_next = bus_reg;
		rd_next = rd_reg;
		wait_next = wait_reg;
		msg_next = 1'b0;
		unused_ps = 1'b0;
		// One wait cycle then acknowledge; bus answer is registered
		case (bus_reg)
			PPM_IDLE: begin
				if (avs_read || avs_write) begin
					bus_next = PPM_DONE;
					wait_next = 1'b0;
					if (avs_address == PPM_OFS_CAP) begin
						rd_next = cap_word;
					end else if (avs_address == PPM_OFS_CSR) begin
						rd_next = csr_word;
					end else if (avs_address == PPM_OFS_LOCK) begin
						rd_next = {31'h0000_0000, lock_reg};
					end else if (avs_address == PPM_OFS_EVT) begin
						rd_next = {30'h0000_0000, cold_off, gen_ok};
					end else begin
						rd_next = PPM_UNMAPPED;
					end
				end
			end
			PPM_DONE: begin
				bus_next = PPM_IDLE;
				wait_next = 1'b1;
			end
			default: bus_next = PPM_IDLE;
		endcase
		if (wr_ok && avs_address == PPM_OFS_LOCK && avs_byteenable[0]) begin
			lock_next = avs_writedata[0];
		end
		// (RQ20) lockable fields need unlock
		if (wr_ok && !lock_reg && avs_address == PPM_OFS_CAP) begin
			if (avs_byteenable[1]) begin
				regs_next.next_ptr = avs_writedata[15:8];
			end
			// (RQ4) special-init lockable
			if (avs_byteenable[2]) begin
				regs_next.special = avs_writedata[PPM_SPECIAL_BIT];
			end
			// (RQ8) advertised value only
			if (avs_byteenable[3]) begin
				regs_next.pme_adv = avs_writedata[31:PPM_PME_LSB];
			end
		end
		if (wr_csr && avs_byteenable[0]) begin
			// (RQ10) (RQ21) only D0 and D3hot taken
			if (avs_writedata[1:0] == PPM_PS_D0 || avs_writedata[1:0] == PPM_PS_D3) begin
				regs_next.power_state_field = avs_writedata[1:0];
			end else begin
				unused_ps = 1'b1;
			end
			// (RQ11) context bit lockable
			if (!lock_reg) begin
				regs_next.keep_ctx = avs_writedata[PPM_NOSR_BIT];
			end
		end
		// (RQ11) restore next pointer on a CSR write from D3hot to D0 when not kept (not on hot reset)
		if (regs_reg.power_state_field == PPM_PS_D3 && regs_next.power_state_field == PPM_PS_D0 && !regs_reg.keep_ctx) begin
			regs_next.next_ptr = UPSTREAM ? PPM_NXT_UP : PPM_NXT_DN;
		end
		// Hot reset returns power state to D0; enable and status stay
		if (hot_reset) begin
			regs_next.power_state_field = PPM_PS_D0;
		end
		// (RQ12) (RQ9) own message needs enable; own and forwarded need power
		msg_next = !cold_off && ((pme_local && gen_ok && en_bit) || pme_fwd_in);
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			bus_reg <= PPM_IDLE;
			regs_reg <= '{next_ptr: (UPSTREAM ? PPM_NXT_UP : PPM_NXT_DN), special: 1'b0,
				pme_adv: PPM_PME_RST, power_state_field: PPM_PS_D0, keep_ctx: PPM_NOSR_RST};
			lock_reg <= 1'b0;
			rd_reg <= 32'h0000_0000;
			wait_reg <= 1'b1;
			msg_reg <= 1'b0;
		end else begin
			bus_reg <= bus_next;
			regs_reg <= regs_next;
			lock_reg <= lock_next;
			rd_reg <= rd_next;
			wait_reg <= wait_next;
			msg_reg <= msg_next;
		end
	end

	assign avs_readdata = rd_reg;
	assign avs_waitrequest = wait_reg;
	assign pme_msg = msg_reg;
	assign power_state = regs_reg.power_state_field;
	assign pme_enable = en_bit;

	// ****************************************
	// Checks
	// ****************************************
	sequence s_own_event;
		pme_local && gen_ok;
	endsequence

	property p_status_sets;
		@(posedge clk_sys) disable iff (!arst_n) s_own_event |=> st_bit;
	endproperty
	a_status_sets: assert property (p_status_sets) else $error("status not set"); // (RQ15)

	property p_upstream_quiet;
		@(posedge clk_sys) disable iff (!arst_n) UPSTREAM |-> !st_bit;
	endproperty
	a_upstream_quiet: assert property (p_upstream_quiet) else $error("upstream status set"); // (RQ17)

	property p_fwd_no_status;
		@(posedge clk_sys) disable iff (!arst_n) (pme_fwd_in && !pme_local && !st_bit) |=> !st_bit;
	endproperty
	a_fwd_no_status: assert property (p_fwd_no_status) else $error("forward set status"); // (RQ16)

	property p_cold_quiet;
		@(posedge clk_sys) disable iff (!arst_n) cold_off |=> !pme_msg;
	endproperty
	a_cold_quiet: assert property (p_cold_quiet) else $error("message while cold"); // (RQ9)

	property p_ps_legal;
		@(posedge clk_sys) disable iff (!arst_n) power_state == PPM_PS_D0 || power_state == PPM_PS_D3;
	endproperty
	a_ps_legal: assert property (p_ps_legal) else $error("illegal power state"); // (RQ10)

	property p_ps_ignore;
		@(posedge clk_sys) disable iff (!arst_n) (unused_ps && !hot_reset) |=> $stable(power_state);
	endproperty
	a_ps_ignore: assert property (p_ps_ignore) else $error("reserved state taken"); // (RQ21)

	property p_hot_keep_en;
		@(posedge clk_sys) disable iff (!arst_n) (hot_reset && !wr_csr) |=> $stable(pme_enable);
	endproperty
	a_hot_keep_en: assert property (p_hot_keep_en) else $error("enable lost on hot reset"); // (RQ13)

	property p_lock_holds;
		@(posedge clk_sys) disable iff (!arst_n) (lock_reg && !(wr_csr && regs_reg.power_state_field == PPM_PS_D3))
			|=> $stable(regs_reg.pme_adv) && $stable(regs_reg.special);
	endproperty
	a_lock_holds: assert property (p_lock_holds) else $error("locked field changed"); // (RQ20)

	property p_no_en_no_msg;
		@(posedge clk_sys) disable iff (!arst_n) (!en_bit && !pme_fwd_in) |=> !pme_msg;
	endproperty
	a_no_en_no_msg: assert property (p_no_en_no_msg) else $error("message without enable"); // (RQ12)

	property p_cap_fixed;
		@(posedge clk_sys) disable iff (!arst_n) cap_word[7:0] == PPM_CAP_ID && cap_word[26:16] ==
			{5'h00, regs_reg.special, 1'b0, 1'b0, PPM_VERSION};
	endproperty
	a_cap_fixed: assert property (p_cap_fixed) else $error("capability fields wrong"); // (RQ2)
endmodule : ppm_regs

// *** bench/ppm_root_model.sv ***
`timescale 1ns/1ps
module ppm_root_model (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// Message from the port
	input wire logic pme_msg,
	// Observed traffic
	output logic [7:0] msg_count
);
	// A stuck-high message line would count every cycle and show up at once
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			msg_count <= 8'h00;
		end else if (pme_msg) begin
			msg_count <= msg_count + 8'h01;
		end
	end
endmodule : ppm_root_model

// *** bench/tb.sv ***
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
	$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
	import ppm_pkg::*;
	logic clk_sys, arst_n, hot_reset, avs_read, avs_write, pme_local, pme_fwd_in, cold_off;
	logic avs_waitrequest, up_wait, pme_msg, pme_enable;
	logic [7:0] avs_address, msg_count, exp_msgs;
	logic [31:0] avs_writedata, avs_readdata, up_readdata, q, uq;
	logic [3:0] avs_byteenable;
	logic [1:0] power_state;
	logic [1:0] codes [4] = '{2'h3, 2'h1, 2'h2, 2'h0};
	logic [1:0] keeps [4] = '{2'h3, 2'h3, 2'h3, 2'h0};
	int bad_count, tests_run;

	ppm_regs #(.UPSTREAM(1'b0)) uut (.clk_sys(clk_sys), .arst_n(arst_n), .hot_reset(hot_reset),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.pme_local(pme_local), .pme_fwd_in(pme_fwd_in), .cold_off(cold_off), .pme_msg(pme_msg),
		.power_state(power_state), .pme_enable(pme_enable));
	// Upstream twin shares the bus; only its read data and waitrequest are looked at
	ppm_regs #(.UPSTREAM(1'b1)) uut_up (.clk_sys(clk_sys), .arst_n(arst_n), .hot_reset(hot_reset),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(up_readdata), .avs_waitrequest(up_wait),
		.pme_local(pme_local), .pme_fwd_in(pme_fwd_in), .cold_off(cold_off), .pme_msg(),
		.power_state(), .pme_enable());
	ppm_root_model root (.clk_sys(clk_sys), .arst_n(arst_n), .pme_msg(pme_msg), .msg_count(msg_count));

	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	// ****************************************
	// Bus and event tasks
	// ****************************************
	// Request stands until the edge that samples waitrequest low; read data is taken there
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
		@(posedge clk_sys);
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= be;
		avs_write <= wr;
		avs_read <= ~wr;
		do begin
			@(posedge clk_sys);
		end while (avs_waitrequest !== 1'b0 || up_wait !== 1'b0);
		q = avs_readdata;
		uq = up_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		// One idle edge lets a write settle before the caller looks at outputs
		@(posedge clk_sys);
	endtask : bus

	task automatic pulse(input logic loc, input logic fwd);
		@(posedge clk_sys);
		pme_local <= loc;
		pme_fwd_in <= fwd;
		@(posedge clk_sys);
		pme_local <= 1'b0;
		pme_fwd_in <= 1'b0;
		repeat (3) @(posedge clk_sys);
	endtask : pulse

	task automatic note(input string s);
		$display("test %s done", s);
	endtask : note

	task automatic finish_test;
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : finish_test

	initial begin
		repeat (3000) @(posedge clk_sys);
		bad_count++;
		finish_test();
	end

	// ****************************************
	// Tests
	// ****************************************
	initial begin
		{arst_n, hot_reset, avs_read, avs_write, pme_local, pme_fwd_in, cold_off} = 7'h00;
		avs_address = 8'h00;
		avs_writedata = 32'h0000_0000;
		avs_byteenable = 4'h0;
		bad_count = 0;
		tests_run = 0;
		exp_msgs = 8'h00;
		repeat (16) @(posedge clk_sys);
		arst_n <= 1'b1;
		bus(1'b0, PPM_OFS_CAP, 32'h0, 4'hF);
		`CHK(q, 32'hC803_D001)
		`CHK(uq, 32'hC803_0001)
		bus(1'b0, PPM_OFS_CSR, 32'h0, 4'hF);
		`CHK(q, 32'h0000_0008)
		bus(1'b0, 8'hF0, 32'h0, 4'hF);
		`CHK(q, PPM_UNMAPPED)
		note("reset");
		bus(1'b1, PPM_OFS_CAP, 32'hFFFF_FFFF, 4'hF);
		bus(1'b0, PPM_OFS_CAP, 32'h0, 4'hF);
		`CHK(q, 32'hF823_FF01)
		bus(1'b1, PPM_OFS_CAP, 32'h0, 4'hF);
		bus(1'b0, PPM_OFS_CAP, 32'h0, 4'hF);
		`CHK(q, 32'h0003_0001)
		bus(1'b1, PPM_OFS_CSR, 32'h0000_0100, 4'h2);
		`CHK(pme_enable, 1'b1)
		pulse(1'b1, 1'b0);
		exp_msgs++;
		`CHK(msg_count, exp_msgs)
		bus(1'b1, PPM_OFS_CAP, 32'hC803_D001, 4'hF);
		bus(1'b1, PPM_OFS_LOCK, 32'h0000_0001, 4'hF);
		bus(1'b1, PPM_OFS_CAP, 32'hFFFF_FFFF, 4'hF);
		bus(1'b0, PPM_OFS_CAP, 32'h0, 4'hF);
		`CHK(q, 32'hC803_D001)
		bus(1'b1, PPM_OFS_CSR, 32'h0000_0100, 4'h3);
		bus(1'b0, PPM_OFS_CSR, 32'h0, 4'hF);
		`CHK(q, 32'h0000_8108)
		`CHK(uq, 32'h0000_0108)
		note("lock");
		for (int i = 0; i < 4; i++) begin
			bus(1'b1, PPM_OFS_CSR, {30'h0, codes[i]}, 4'h1);
			`CHK(power_state, keeps[i])
			bus(1'b0, PPM_OFS_CSR, 32'h0, 4'hF);
			`CHK(q[1:0], keeps[i])
		end
		note("power state");
		bus(1'b1, PPM_OFS_CSR, 32'h0000_8100, 4'h2);
		bus(1'b0, PPM_OFS_CSR, 32'h0, 4'hF);
		`CHK(q, 32'h0000_0108)
		pulse(1'b0, 1'b1);
		exp_msgs++;
		`CHK(msg_count, exp_msgs)
		bus(1'b0, PPM_OFS_CSR, 32'h0, 4'hF);
		`CHK(q, 32'h0000_0108)
		bus(1'b1, PPM_OFS_CSR, 32'h0, 4'h2);
		pulse(1'b1, 1'b0);
		`CHK(msg_count, exp_msgs)
		bus(1'b0, PPM_OFS_CSR, 32'h0, 4'hF);
		`CHK(q, 32'h0000_8008)
		cold_off <= 1'b1;
		pulse(1'b0, 1'b1);
		`CHK(msg_count, exp_msgs)
		cold_off <= 1'b0;
		note("pme");
		bus(1'b1, PPM_OFS_CSR, 32'h0000_0103, 4'h3);
		hot_reset <= 1'b1;
		repeat (2) @(posedge clk_sys);
		hot_reset <= 1'b0;
		@(posedge clk_sys);
		`CHK(power_state, PPM_PS_D0)
		`CHK(pme_enable, 1'b1)
		bus(1'b0, PPM_OFS_CSR, 32'h0, 4'hF);
		`CHK(q, 32'h0000_8108)
		note("hot reset");
		// Context bit cleared while unlocked: leaving the hot low-power state restores the pointer
		bus(1'b1, PPM_OFS_LOCK, 32'h0000_0000, 4'hF);
		bus(1'b1, PPM_OFS_CAP, 32'hC803_AA01, 4'hF);
		bus(1'b1, PPM_OFS_CSR, 32'h0000_0003, 4'h1);
		bus(1'b1, PPM_OFS_CSR, 32'h0000_0000, 4'h1);
		bus(1'b0, PPM_OFS_CAP, 32'h0, 4'hF);
		`CHK(q, 32'hC803_D001)
		`CHK(uq, 32'hC803_0001)
		bus(1'b0, PPM_OFS_CSR, 32'h0, 4'hF);
		`CHK(q, 32'h0000_8100)
		note("context loss");
		finish_test();
	end
endmodule : tb
